// >>> rtl/csc_pkg.sv
// Package of the CPU status and core-control register block.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package csc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CSC_STATUS_OFF   = 8'h00;
  localparam logic [7:0] CSC_CORE_OFF     = 8'h04;
  localparam logic [7:0] CSC_PAGE_OFF     = 8'h08;
  localparam logic [7:0] CSC_NEST_OFF     = 8'h0C;
  localparam logic [7:0] CSC_ANCFG_OFF    = 8'h10;
  localparam logic [7:0] CSC_PORTIN_OFF   = 8'h14;
  localparam logic [7:0] CSC_REPEAT_OFF   = 8'h18;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int CSC_HC_BIT  = 8;
  localparam int CSC_PLL_HI  = 7;
  localparam int CSC_PLL_LO  = 5;
  localparam int CSC_RA_BIT  = 4;
  localparam int CSC_N_BIT   = 3;
  localparam int CSC_OV_BIT  = 2;
  localparam int CSC_Z_BIT   = 1;
  localparam int CSC_C_BIT   = 0;
  localparam logic [15:0] CSC_STATUS_MASK = 16'h01FF;

  // Core control fields
  localparam int CSC_PMSB_BIT = 3;
  localparam int CSC_PWIN_BIT = 2;
  localparam logic [15:0] CSC_CORE_MASK = 16'h000C;

  // Reset values
  localparam logic [15:0] CSC_STATUS_RST = 16'h0000;
  localparam logic [15:0] CSC_CORE_RST   = 16'h0000;
  localparam logic [7:0]  CSC_PAGE_RST   = 8'h00;

  // Divide timing and level limits
  localparam logic [4:0] CSC_DIV_CYCLES = 5'h13;
  localparam logic [3:0] CSC_LEVEL_USER_MAX = 4'h7;

  // Repeat engine states
  typedef enum logic [1:0] {
    CSC_RPT_IDLE = 2'b00,
    CSC_RPT_RUN  = 2'b01,
    CSC_RPT_HOLD = 2'b11
  } csc_rpt_t;

endpackage : csc_pkg

// >>> rtl/csc_flag_calc.sv
// Flag computation for byte and word ALU results.
// Assumes operands and carry-in are valid in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module csc_flag_calc (
  input  wire logic [15:0] opa,
  input  wire logic [15:0] opb,
  input  wire logic        cin,
  input  wire logic        byte_op,
  output logic      [15:0] result,
  output logic      [4:0]  flags
);
  logic [16:0] sum;
  logic [8:0]  nib;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;
  logic        cout;
  logic        hcar;
  logic        zero;

  // ----------------------------------------------------------------
  // Adder and flags, flag order {half, neg, wrap, zero, carry}
  // ----------------------------------------------------------------
  always_comb begin
    sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
    nib = byte_op ? {4'h0, {1'b0, opa[3:0]} + {1'b0, opb[3:0]}
                           + {4'h0, cin}}
                  : {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
    hcar   = byte_op ? nib[4] : nib[8];
    result = byte_op ? {8'h00, sum[7:0]} : sum[15:0];
    msb_a  = byte_op ? opa[7] : opa[15];
    msb_b  = byte_op ? opb[7] : opb[15];
    msb_r  = byte_op ? sum[7] : sum[15];
    cout   = byte_op ? (sum[8] ^ opa[8] ^ opb[8]) : sum[16];
    zero   = byte_op ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
    flags  = {hcar, msb_r, (msb_a == msb_b) && (msb_r != msb_a),
              zero, cout};
  end
endmodule : csc_flag_calc
`default_nettype wire

// >>> rtl/csc_repeat_ctl.sv
// Repeat loop sequencer; holds the remaining count across interrupts.
// Assumes start is a one-cycle pulse from the instruction datapath.
`timescale 1ns/1ns
`default_nettype none
module csc_repeat_ctl
  import csc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic [4:0] count,
  input  wire logic       irq_take,
  output logic            active,
  output logic            done
);
  csc_rpt_t   state;
  logic [4:0] left;

  // ----------------------------------------------------------------
  // Loop engine
  // ----------------------------------------------------------------
  // Interrupt only pauses the count, so no iteration is lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CSC_RPT_IDLE;
      left  <= 5'h00;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        CSC_RPT_IDLE: begin
          if (start && count != 5'h00) begin
            left  <= count;
            state <= CSC_RPT_RUN;
          end
        end
        CSC_RPT_RUN: begin
          if (irq_take) begin
            state <= CSC_RPT_HOLD;
          end else if (left == 5'h01) begin
            left  <= 5'h00;
            done  <= 1'b1;
            state <= CSC_RPT_IDLE;
          end else begin
            left <= left - 5'h01;
          end
        end
        // Resume counts at once, so the pause costs no extra cycle
        CSC_RPT_HOLD: begin
          if (!irq_take) begin
            if (left == 5'h01) begin
              left  <= 5'h00;
              done  <= 1'b1;
              state <= CSC_RPT_IDLE;
            end else begin
              left  <= left - 5'h01;
              state <= CSC_RPT_RUN;
            end
          end
        end
        default: state <= CSC_RPT_IDLE;
      endcase
    end
  end

  assign active = (state != CSC_RPT_IDLE);
endmodule : csc_repeat_ctl
`default_nettype wire

// >>> rtl/csc_core.sv
// CPU status and core-control register bank with APB access.
// Assumes one synchronous clock domain; datapath events are one-cycle
// pulses that arrive synchronous to mclk.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module csc_core
  import csc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        alu_valid,
  input  wire logic [15:0] alu_opa,
  input  wire logic [15:0] alu_opb,
  input  wire logic        alu_cin,
  input  wire logic        alu_byte,
  input  wire logic        alu_zero_sticky,
  input  wire logic        div_start,
  input  wire logic        irq_take,
  input  wire logic        level_load,
  input  wire logic [3:0]  level_value,
  input  wire logic        wreg_we,
  input  wire logic [3:0]  wreg_waddr,
  input  wire logic [15:0] wreg_wdata,
  input  wire logic [3:0]  wreg_raddr,
  output logic      [15:0] wreg_rdata,
  output logic      [15:0] stack_ptr,
  input  wire logic [15:0] dmem_addr,
  output logic             prog_sel,
  output logic      [23:0] prog_addr,
  input  wire logic [15:0] pin_level,
  output logic      [15:0] port_value,
  output logic      [15:0] alu_result,
  output logic             user_irq_en,
  output logic             div_busy,
  output logic             div_done
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] status;
  logic [15:0] core_ctl;
  logic [7:0]  visibility_page;
  logic        nesting_disable;
  logic [15:0] analog_pin_config;
  logic [15:0] wreg [0:15];
  logic [15:0] calc_result;
  logic [4:0]  calc_flags;
  logic        rpt_active;
  logic        rpt_done;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] next_prdata;
  logic [3:0]  level_full;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  csc_flag_calc u_flags (
    .opa     (alu_opa),
    .opb     (alu_opb),
    .cin     (alu_cin),
    .byte_op (alu_byte),
    .result  (calc_result),
    .flags   (calc_flags)
  );

  // Divide is a fixed 19-cycle repeat run
  csc_repeat_ctl u_rpt (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .start    (div_start),
    .count    (CSC_DIV_CYCLES),
    .irq_take (irq_take),
    .active   (rpt_active),
    .done     (rpt_done)
  );

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // ALU update wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status <= CSC_STATUS_RST;
    end else begin
      if (wr_en && paddr == CSC_STATUS_OFF) begin
        status[CSC_HC_BIT] <= pwdata[CSC_HC_BIT];
        status[3:0]        <= pwdata[3:0];
        if (!nesting_disable) begin
          status[CSC_PLL_HI:CSC_PLL_LO] <= pwdata[7:5];
        end
      end
      if (level_load) begin
        status[CSC_PLL_HI:CSC_PLL_LO] <= level_value[2:0];
      end
      if (alu_valid) begin
        status[CSC_HC_BIT] <= calc_flags[4];
        status[CSC_N_BIT]  <= calc_flags[3];
        status[CSC_OV_BIT] <= calc_flags[2];
        status[CSC_C_BIT]  <= calc_flags[0];
        if (!calc_flags[1]) begin
          status[CSC_Z_BIT] <= 1'b0;
        end else if (!alu_zero_sticky) begin
          status[CSC_Z_BIT] <= 1'b1;
        end
      end
      status[CSC_RA_BIT] <= rpt_active;
      status[15:9]       <= 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // Core control and auxiliary registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_ctl <= CSC_CORE_RST;
    end else begin
      if (wr_en && paddr == CSC_CORE_OFF) begin
        core_ctl[CSC_PWIN_BIT] <= pwdata[CSC_PWIN_BIT];
      end
      if (level_load) begin
        core_ctl[CSC_PMSB_BIT] <= (level_value > CSC_LEVEL_USER_MAX);
      end
      core_ctl[15:4] <= 12'h000;
      core_ctl[1:0]  <= 2'h0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      visibility_page   <= CSC_PAGE_RST;
      nesting_disable   <= 1'b0;
      analog_pin_config <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        CSC_PAGE_OFF:  visibility_page   <= pwdata[7:0];
        CSC_NEST_OFF:  nesting_disable   <= pwdata[0];
        CSC_ANCFG_OFF: analog_pin_config <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Working registers, one cycle per write
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wreg_we) begin
      wreg[wreg_waddr] <= wreg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wreg_rdata <= 16'h0000;
      stack_ptr  <= 16'h0000;
    end else begin
      wreg_rdata <= wreg[wreg_raddr];
      stack_ptr  <= (wreg_we && wreg_waddr == 4'hF) ? wreg_wdata
                                                     : stack_ptr;
    end
  end

  // ----------------------------------------------------------------
  // Datapath-facing outputs
  // ----------------------------------------------------------------
  assign level_full = {core_ctl[CSC_PMSB_BIT],
                       status[CSC_PLL_HI:CSC_PLL_LO]};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prog_sel    <= 1'b0;
      prog_addr   <= 24'h000000;
      port_value  <= 16'h0000;
      alu_result  <= 16'h0000;
      user_irq_en <= 1'b0;
      div_busy    <= 1'b0;
      div_done    <= 1'b0;
    end else begin
      prog_sel  <= core_ctl[CSC_PWIN_BIT] && dmem_addr[15];
      prog_addr <= {1'b0, visibility_page, dmem_addr[14:0]};
      port_value <= pin_level & analog_pin_config;
      alu_result <= calc_result;
      user_irq_en <= !level_full[3] && level_full[2:0] != 3'h7;
      div_busy <= rpt_active;
      div_done <= rpt_done;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait, error on unmapped address
  // ----------------------------------------------------------------
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      CSC_STATUS_OFF: next_prdata = {16'h0000, status & CSC_STATUS_MASK};
      CSC_CORE_OFF:   next_prdata = {16'h0000, core_ctl & CSC_CORE_MASK};
      CSC_PAGE_OFF:   next_prdata = {24'h000000, visibility_page};
      CSC_NEST_OFF:   next_prdata = {31'h00000000, nesting_disable};
      CSC_ANCFG_OFF:  next_prdata = {16'h0000, analog_pin_config};
      CSC_PORTIN_OFF: next_prdata = {16'h0000, port_value};
      CSC_REPEAT_OFF: next_prdata = {31'h00000000, rpt_active};
      default: begin
        next_prdata = 32'h00000000;
        addr_ok     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= next_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_div_go;
    div_start && !rpt_active;
  endsequence

  chk_status_zero_hi: assert property (@(posedge mclk) disable iff (!arst_n)
    status[15:9] == 7'h00) else $error("status upper bits set");

  chk_nest_lock: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_en && paddr == CSC_STATUS_OFF && nesting_disable && !level_load)
    |=> $stable(status[7:5])) else $error("level written while locked");

  chk_repeat_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    s_div_go |=> ##1 status[CSC_RA_BIT] [*8])
    else $error("repeat flag low in loop");

  chk_div_length: assert property (@(posedge mclk) disable iff (!arst_n)
    s_div_go ##1 (!irq_take) [*8] ##1 (!irq_take) [*8]
    ##1 (!irq_take) [*3] |=> rpt_done)
    else $error("divide length wrong");

  chk_carry_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    alu_valid |=> status[CSC_C_BIT] == $past(calc_flags[0]))
    else $error("carry flag mismatch");

  chk_zero_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (alu_valid && !calc_flags[1]) |=> !status[CSC_Z_BIT])
    else $error("zero flag not cleared");

  chk_level_msb: assert property (@(posedge mclk) disable iff (!arst_n)
    level_load |=> core_ctl[CSC_PMSB_BIT] == ($past(level_value) > 4'h7))
    else $error("level msb wrong");

  chk_analog_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    !analog_pin_config[0] |=> !port_value[0])
    else $error("analog pin reads high");

  chk_irq_msb: assert property (@(posedge mclk) disable iff (!arst_n)
    core_ctl[CSC_PMSB_BIT] |=> !user_irq_en)
    else $error("user irq with msb set");
endmodule : csc_core
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the status and core-control register bank.
// Assumes csc_pkg and csc_core compiled first; the bench drives all pins.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import csc_pkg::*;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        alu_valid, alu_cin, alu_byte, alu_zero_sticky;
  logic [15:0] alu_opa, alu_opb, alu_result;
  logic        div_start, irq_take, level_load, wreg_we;
  logic [3:0]  level_value, wreg_waddr, wreg_raddr;
  logic [15:0] wreg_wdata, wreg_rdata, stack_ptr, dmem_addr;
  logic        prog_sel, user_irq_en, div_busy, div_done;
  logic [23:0] prog_addr;
  logic [15:0] pin_level, port_value;
  int          fails, samples_checked, busy_cycles, t0, t3;
  // ----------------------------------------------------------------
  // ALU table: operands, byte mode, sticky zero, status, result
  // ----------------------------------------------------------------
  logic [15:0] ta [6] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'h0001,
                          16'h000F, 16'h0070};
  logic [15:0] tb [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0001,
                          16'h0001, 16'h0010};
  logic [5:0]  tbyte  = 6'b110000;
  logic [5:0]  tstk   = 6'b001100;
  logic [15:0] tst [6] = '{16'h010C, 16'h0103, 16'h0002, 16'h0000,
                           16'h0100, 16'h000C};
  logic [15:0] tres [6] = '{16'h8000, 16'h0000, 16'h0000, 16'h0002,
                            16'h0010, 16'h0080};

  csc_core csc_core_inst (
    .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .alu_valid, .alu_opa, .alu_opb, .alu_cin,
    .alu_byte, .alu_zero_sticky, .div_start, .irq_take, .level_load,
    .level_value, .wreg_we, .wreg_waddr, .wreg_wdata, .wreg_raddr,
    .wreg_rdata, .stack_ptr, .dmem_addr, .prog_sel, .prog_addr,
    .pin_level, .port_value, .alu_result, .user_irq_en, .div_busy,
    .div_done
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Counts repeat-active cycles; cleared by the divide task
  always @(posedge mclk) begin
    if (div_busy === 1'b1) busy_cycles++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // One APB transfer; waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc

  task automatic alu(input int i);
    @(posedge mclk);
    alu_valid       <= 1'b1;
    alu_opa         <= ta[i];
    alu_opb         <= tb[i];
    alu_byte        <= tbyte[i];
    alu_zero_sticky <= tstk[i];
    @(posedge mclk);
    alu_valid <= 1'b0;
  endtask : alu

  // Divide with an optional interrupt pause; returns cycles to done
  task automatic divide(input int pause, output int n);
    busy_cycles = 0;
    @(posedge mclk);
    div_start <= 1'b1;
    @(posedge mclk);
    div_start <= 1'b0;
    n = 0;
    while (div_done !== 1'b1 && n < 80) begin
      @(posedge mclk);
      irq_take <= (n >= 4 && n < 4 + pause);
      n++;
    end
    if (div_done !== 1'b1) fails++;
  endtask : divide

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Whole run is far below this; a hang lands here
  initial begin
    #(40 * 20000);
    fails++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {alu_valid, alu_cin, alu_byte, alu_zero_sticky} = '0;
    {alu_opa, alu_opb, div_start, irq_take, level_load} = '0;
    {level_value, wreg_we, wreg_waddr, wreg_wdata, wreg_raddr} = '0;
    {dmem_addr, pin_level} = '0;
    {fails, samples_checked, busy_cycles} = '0;
    arst_n = 1'b0;
    tick(8);
    arst_n <= 1'b1;
    rdc(CSC_STATUS_OFF, 32'h0000_0000);
    rdc(CSC_CORE_OFF, 32'h0000_0000);
    apb(1'b1, CSC_STATUS_OFF, 32'hFFFF_FFFF);
    rdc(CSC_STATUS_OFF, 32'h0000_01EF);
    apb(1'b1, CSC_CORE_OFF, 32'hFFFF_FFFF);
    rdc(CSC_CORE_OFF, 32'h0000_0004);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("test registers done");
    // Each op overwrites the flags written above; level stays at 111
    for (int i = 0; i < 6; i++) begin
      alu(i);
      rdc(CSC_STATUS_OFF, {16'h0000, tst[i] | 16'h00E0});
      chk({16'h0000, alu_result}, {16'h0000, tres[i]});
    end
    $display("test flags done");
    apb(1'b1, CSC_STATUS_OFF, 32'h0000_0000);
    for (int v = 0; v < 16; v++) begin
      @(posedge mclk);
      level_load  <= 1'b1;
      level_value <= 4'(v);
      @(posedge mclk);
      level_load <= 1'b0;
      rdc(CSC_STATUS_OFF, {24'h0, 3'(v), 5'h00});
      rdc(CSC_CORE_OFF, {28'h0, v > 7, 3'h4});
      chk({31'h0, user_irq_en}, {31'h0, v < 7});
    end
    @(posedge mclk);
    level_load  <= 1'b1;
    level_value <= 4'h5;
    @(posedge mclk);
    level_load <= 1'b0;
    apb(1'b1, CSC_NEST_OFF, 32'h0000_0001);
    apb(1'b1, CSC_STATUS_OFF, 32'h0000_0000);
    rdc(CSC_STATUS_OFF, 32'h0000_00A0);
    apb(1'b1, CSC_NEST_OFF, 32'h0000_0000);
    apb(1'b1, CSC_STATUS_OFF, 32'h0000_0060);
    rdc(CSC_STATUS_OFF, 32'h0000_0060);
    $display("test level done");
    // Program window: enable is still set from the all-ones write
    apb(1'b1, CSC_PAGE_OFF, 32'h0000_005A);
    @(posedge mclk);
    dmem_addr <= 16'h8123;
    tick(2);
    chk({7'h0, prog_sel, prog_addr}, {8'h01, 1'b0, 8'h5A, 15'h0123});
    dmem_addr <= 16'h0123;
    tick(2);
    chk({31'h0, prog_sel}, 32'h0);
    apb(1'b1, CSC_CORE_OFF, 32'h0000_0000);
    dmem_addr <= 16'h8123;
    tick(2);
    chk({31'h0, prog_sel}, 32'h0);
    $display("test window done");
    apb(1'b1, CSC_ANCFG_OFF, 32'h0000_00F0);
    pin_level <= 16'hFF3C;
    tick(2);
    chk({16'h0, port_value}, 32'h0000_0030);
    rdc(CSC_PORTIN_OFF, 32'h0000_0030);
    $display("test analog done");
    @(posedge mclk);
    wreg_we    <= 1'b1;
    wreg_waddr <= 4'hF;
    wreg_wdata <= 16'hBEEF;
    @(posedge mclk);
    wreg_waddr <= 4'h3;
    wreg_wdata <= 16'h1234;
    @(posedge mclk);
    wreg_we    <= 1'b0;
    wreg_raddr <= 4'h3;
    tick(2);
    chk({wreg_rdata, stack_ptr}, 32'h1234_BEEF);
    $display("test wregs done");
    // Peek at the loop flag while a divide runs
    @(posedge mclk);
    div_start <= 1'b1;
    @(posedge mclk);
    div_start <= 1'b0;
    rdc(CSC_REPEAT_OFF, 32'h0000_0001);
    apb(1'b0, CSC_STATUS_OFF, 32'h0);
    chk(rd & 32'h10, 32'h10);
    tick(30);
    rdc(CSC_REPEAT_OFF, 32'h0000_0000);
    divide(0, t0);
    chk(32'(busy_cycles), 32'd19);
    divide(3, t3);
    chk(32'(t3 - t0), 32'd3);
    $display("test divide done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
